/* frt_params.svh */
// Constants of the free running timer: offsets, fields, reset values.
// Assumes a byte-wide register port; included by frt_pkg and modules.
`ifndef FRT_PARAMS_SVH
`define FRT_PARAMS_SVH
`define FRT_ADDR_W        4
`define FRT_OFF_CNT_HI    4'h0
`define FRT_OFF_CNT_LO    4'h1
`define FRT_OFF_ALT_HI    4'h2
`define FRT_OFF_ALT_LO    4'h3
`define FRT_OFF_STATUS    4'h4
`define FRT_OFF_CTRL_ONE  4'h5
`define FRT_OFF_CTRL_TWO  4'h6
`define FRT_OFF_IRQ_MASK  4'h7
`define FRT_CNT_RESET     16'hfffc
`define FRT_CNT_MAX       16'hffff
`define FRT_BIT_OVF       0
`define FRT_BIT_OVF_IE    5
`define FRT_BIT_EDGE      1
`define FRT_SYNC_GAP      3'h4
`endif

/* frt_pkg.sv */
// Types of the free running timer.
// Assumes frt_params.svh is visible on the include path.
`include "frt_params.svh"
package frt_pkg;
  typedef enum logic [1:0] {
    FRT_DIV2, FRT_DIV4, FRT_DIV8, FRT_EXT
  } frt_clk_sel_t;
  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [`FRT_ADDR_W-1:0]   addr;
    logic [7:0]               wdata;
  } frt_bus_req_t;
  typedef enum logic {FRT_RD_IDLE, FRT_RD_HELD} frt_rd_state_t;
endpackage

/* frt_prescaler.sv */
// Timer tick source: divide by 2/4/8 or synchronised external edge.
// Assumes ext_clk_pin is asynchronous to clk; one tick per active edge.
`timescale 1ns/1ps
`include "frt_params.svh"
module frt_prescaler (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                run,
  input  wire frt_pkg::frt_clk_sel_t sel,
  input  wire logic                edge_rise,
  input  wire logic                ext_clk_pin,
  output logic                     tick
);
  logic [2:0] div;
  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       ext_edge;
  logic       int_tick;

  always_ff @(posedge clk) begin
    if (reset) begin
      div <= 3'h0;
    end else if (run) begin
      div <= div + 3'h1;
    end
  end

  // Two-stage synchroniser, third stage only for edge detection
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
    end else begin
      sync1 <= ext_clk_pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // Edge taken on the chosen transition only
  assign ext_edge = edge_rise ? (sync2 & ~sync3) : (~sync2 & sync3);

  always_comb begin
    unique case (sel)
      frt_pkg::FRT_DIV2: int_tick = div[0];
      frt_pkg::FRT_DIV4: int_tick = div[1:0] == 2'h3;
      frt_pkg::FRT_DIV8: int_tick = div == 3'h7;
      frt_pkg::FRT_EXT:  int_tick = 1'b0;
    endcase
  end

  // Prescaler or pin, never both
  assign tick = run & ((sel == frt_pkg::FRT_EXT) ? ext_edge : int_tick);
endmodule

/* frt_read_latch.sv */
// Low-byte buffer of the two-byte counter read sequence.
// Assumes one-cycle read strobes decoded by the timer top.
`timescale 1ns/1ps
module frt_read_latch (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       hi_read,
  input  wire logic       lo_read,
  input  wire logic [7:0] live_lo,
  output logic [7:0]      lo_value,
  output logic            held
);
  frt_pkg::frt_rd_state_t state;
  logic [7:0]             lo_buf;

  // Repeated high reads keep the first buffered byte
  always_ff @(posedge clk) begin
    if (reset) begin
      state  <= frt_pkg::FRT_RD_IDLE;
      lo_buf <= 8'h00;
    end else begin
      unique case (state)
        frt_pkg::FRT_RD_IDLE: if (hi_read) begin
          state  <= frt_pkg::FRT_RD_HELD;
          lo_buf <= live_lo;
        end
        frt_pkg::FRT_RD_HELD: if (lo_read) begin
          state <= frt_pkg::FRT_RD_IDLE;
        end
      endcase
    end
  end

  assign held = state == frt_pkg::FRT_RD_HELD;
  // Live byte outside a sequence
  assign lo_value = held ? lo_buf : live_lo;
endmodule

/* frt_timer.sv */
// Free running 16-bit timer core with byte-wide register port.
// Assumes a one-clock CPU bus master; halt and cpu_irq_mask from the core.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "frt_params.svh"
module frt_timer #(
  parameter bit EXT_PIN_BONDED = 1'b1
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic [`FRT_ADDR_W-1:0]    addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic [7:0]                     rdata,
  input  wire logic                      ext_clk_pin,
  input  wire logic                      halt,
  input  wire logic                      cpu_irq_mask,
  output logic                           irq
);
  frt_pkg::frt_bus_req_t req;
  logic [15:0]           count;
  logic [1:0]            clock_select_field;
  logic                  external_edge_select;
  logic                  overflow_irq_enable;
  logic                  overflow_flag;
  logic                  clr_armed;
  logic                  irq_mask;
  logic                  tick;
  logic                  pin_in;
  logic                  wrap;
  logic                  hi_read;
  logic                  lo_read;
  logic                  lo_write;
  logic                  prim_lo_acc;
  logic                  stat_read;
  logic [7:0]            lo_value;
  logic                  seq_held;
  logic [7:0]            next_rdata;

  assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  // Missing pin is read as high
  assign pin_in = EXT_PIN_BONDED ? ext_clk_pin : 1'b1;

  assign hi_read = req.rd & (req.addr == `FRT_OFF_CNT_HI
                           || req.addr == `FRT_OFF_ALT_HI);
  assign lo_read = req.rd & (req.addr == `FRT_OFF_CNT_LO
                           || req.addr == `FRT_OFF_ALT_LO);
  assign lo_write = req.wr & (req.addr == `FRT_OFF_CNT_LO
                            || req.addr == `FRT_OFF_ALT_LO);
  // Only the primary low byte counts toward the flag clear
  assign prim_lo_acc = (req.rd | req.wr) & req.addr == `FRT_OFF_CNT_LO;
  assign stat_read = req.rd & req.addr == `FRT_OFF_STATUS;

  // Wait does not stop the prescaler; only halt does
  frt_prescaler u_presc (
    .clk         (clk),
    .reset       (reset),
    .run         (~halt),
    .sel         (frt_pkg::frt_clk_sel_t'(clock_select_field)),
    .edge_rise   (external_edge_select),
    .ext_clk_pin (pin_in),
    .tick        (tick)
  );

  frt_read_latch u_latch (
    .clk      (clk),
    .reset    (reset),
    .hi_read  (hi_read),
    .lo_read  (lo_read),
    .live_lo  (count[7:0]),
    .lo_value (lo_value),
    .held     (seq_held)
  );

  assign wrap = tick & (count == `FRT_CNT_MAX);

  // Only FFFC is ever loaded
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= `FRT_CNT_RESET;
    end else if (lo_write) begin
      count <= `FRT_CNT_RESET;
    end else if (tick) begin
      count <= count + 16'h0001;
    end
  end

  // Control bits written by software
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_select_field   <= 2'h0;
      external_edge_select <= 1'b0;
      overflow_irq_enable  <= 1'b0;
      irq_mask             <= 1'b1;
    end else if (req.wr) begin
      if (req.addr == `FRT_OFF_CTRL_TWO) begin
        clock_select_field   <= req.wdata[3:2];
        external_edge_select <= req.wdata[`FRT_BIT_EDGE];
      end
      if (req.addr == `FRT_OFF_CTRL_ONE) begin
        overflow_irq_enable <= req.wdata[`FRT_BIT_OVF_IE];
      end
      if (req.addr == `FRT_OFF_IRQ_MASK) begin
        irq_mask <= req.wdata[`FRT_BIT_OVF];
      end
    end
  end

  // Two-step clear; a wrap in the clearing cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      overflow_flag <= 1'b0;
      clr_armed     <= 1'b0;
    end else begin
      if (wrap) begin
        overflow_flag <= 1'b1;
      end else if (clr_armed & prim_lo_acc) begin
        overflow_flag <= 1'b0;
      end
      if (stat_read & overflow_flag) begin
        clr_armed <= 1'b1;
      end else if (prim_lo_acc | ~overflow_flag) begin
        clr_armed <= 1'b0;
      end
    end
  end

  // Pending until enable, irq_mask and CPU mask allow it
  assign irq = overflow_flag & overflow_irq_enable & ~cpu_irq_mask
             & irq_mask;

  // Both views show the same count
  always_comb begin
    next_rdata = 8'h00;
    unique case (req.addr)
      `FRT_OFF_CNT_HI, `FRT_OFF_ALT_HI: next_rdata = count[15:8];
      `FRT_OFF_CNT_LO, `FRT_OFF_ALT_LO: next_rdata = lo_value;
      `FRT_OFF_STATUS:   next_rdata = {7'h00, overflow_flag};
      `FRT_OFF_CTRL_ONE: next_rdata = {2'h0, overflow_irq_enable, 5'h00};
      `FRT_OFF_CTRL_TWO: next_rdata = {4'h0, clock_select_field,
                                       external_edge_select, 1'b0};
      `FRT_OFF_IRQ_MASK: next_rdata = {7'h00, irq_mask};
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= req.rd ? next_rdata : 8'h00;
    end
  end

  // Assertions
  sequence s_status_seen;
    stat_read && overflow_flag;
  endsequence

  a_count_reload: assert property (@(posedge clk) disable iff (reset)
    lo_write |=> count == 16'hfffc)
    else $error("count not reloaded after low byte write");
  a_count_step: assert property (@(posedge clk) disable iff (reset)
    tick && !lo_write |=> count == $past(count) + 16'h0001)
    else $error("count did not step on tick");
  a_count_frozen: assert property (@(posedge clk) disable iff (reset)
    halt && !lo_write |=> $stable(count))
    else $error("count moved during halt");
  a_div2_rate: assert property (@(posedge clk) disable iff (reset)
    tick && clock_select_field == 2'h0 && !halt ##1 !halt
      |-> !tick)
    else $error("divide by two ticked twice in a row");
  a_overflow_set: assert property (@(posedge clk) disable iff (reset)
    wrap |=> overflow_flag && count == 16'h0000)
    else $error("wrap did not set the overflow flag");
  a_alt_keeps_flag: assert property (@(posedge clk) disable iff (reset)
    (req.rd || req.wr) && req.addr == `FRT_OFF_ALT_LO && overflow_flag
      |=> overflow_flag)
    else $error("alternate access cleared the flag");
  a_two_step_clear: assert property (@(posedge clk) disable iff (reset)
    s_status_seen ##1 (prim_lo_acc && !wrap && !stat_read)
      |=> !overflow_flag)
    else $error("flag survived the two-step clear");
  a_single_step: assert property (@(posedge clk) disable iff (reset)
    prim_lo_acc && !clr_armed && overflow_flag |=> overflow_flag)
    else $error("flag cleared without status read");
  a_irq_gate: assert property (@(posedge clk) disable iff (reset)
    irq |-> overflow_flag && overflow_irq_enable && !cpu_irq_mask)
    else $error("interrupt without its conditions");
  a_low_held: assert property (@(posedge clk) disable iff (reset)
    hi_read && !seq_held ##1 (!lo_read)[*2]
      |-> lo_value == $past(count[7:0], 2))
    else $error("buffered low byte changed");
endmodule

/* frt_ext_src.sv */
// External clock source for the timer's clock pin.
// Assumes the bench calls toggle while the timer is in external mode.
`timescale 1ns/1ps
module frt_ext_src #(
  parameter int GAP = 6
) (
  input  wire logic clk,
  output logic      pin
);
  initial pin = 1'b0;
  // Keeps more than four clocks between active edges
  task automatic toggle(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (GAP) @(posedge clk);
      pin <= ~pin;
    end
  endtask
endmodule

/* tb_top.sv */
// Self-checking bench of the free running timer.
// Assumes the byte register map and halt freezing the tick source.
`timescale 1ns/1ps
`include "frt_params.svh"
module tb_top;
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  logic [`FRT_ADDR_W-1:0] addr = '0;
  logic [7:0]             wdata = 8'h00;
  logic                   wr = 1'b0;
  logic                   rd = 1'b0;
  logic [7:0]             rdata;
  logic                   ext_pin;
  logic                   halt = 1'b1;
  logic                   cpu_mask = 1'b0;
  logic                   irq;
  int                     num_errors = 0;
  int                     checks_done = 0;
  logic [31:0]            seed = 32'h1475;
  logic [15:0]            w;
  logic [7:0]             v;
  int                     n;

  always #2 clk = ~clk;

  frt_timer u_frt_timer (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ext_clk_pin(ext_pin),
    .halt(halt), .cpu_irq_mask(cpu_mask), .irq(irq));
  frt_ext_src u_frt_ext_src (.clk(clk), .pin(ext_pin));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Prescaler phase survives select changes, so allow one tick of slack
  task automatic near(input logic [15:0] got, input logic [15:0] exp);
    chk({15'h0, 16'(got - exp + 16'h1) < 16'd3}, 16'h1);
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rd16(input logic [3:0] a, output logic [15:0] d);
    rd_reg(a, d[15:8]);
    rd_reg(a + 4'h1, d[7:0]);
  endtask

  task automatic run(input int c);
    @(posedge clk);
    halt <= 1'b0;
    repeat (c) @(posedge clk);
    halt <= 1'b1;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd16(`FRT_OFF_CNT_HI, w);
    chk(w, `FRT_CNT_RESET);
    rd16(`FRT_OFF_ALT_HI, w);
    chk(w, `FRT_CNT_RESET);
    rd_reg(4'h9, v);
    chk(v, 16'h0000);
    wr_reg(`FRT_OFF_CTRL_ONE, 8'h20);
    run(16);
    rd_reg(`FRT_OFF_STATUS, v);
    chk(v[0], 1'b1);
    chk(irq, 1'b1);
    wr_reg(`FRT_OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr_reg(`FRT_OFF_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    cpu_mask <= 1'b1;
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    rd_reg(`FRT_OFF_ALT_LO, v);
    rd_reg(`FRT_OFF_STATUS, v);
    chk(v[0], 1'b1);
    rd_reg(`FRT_OFF_CNT_LO, v);
    rd_reg(`FRT_OFF_STATUS, v);
    chk(v[0], 1'b0);
    cpu_mask <= 1'b0;
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    for (int s = 0; s < 3; s++) begin
      seed = xs(seed);
      n = (2 << s) * (seed % 16 + 1);
      wr_reg(`FRT_OFF_CTRL_TWO, 8'(s << 2));
      run(20);
      wr_reg(s[0] ? `FRT_OFF_ALT_LO : `FRT_OFF_CNT_LO, 8'h55);
      rd16(`FRT_OFF_CNT_HI, w);
      chk(w, `FRT_CNT_RESET);
      run(n);
      rd16(`FRT_OFF_CNT_HI, w);
      near(w, `FRT_CNT_RESET + 16'(n >> (s + 1)));
    end
    wr_reg(`FRT_OFF_CNT_LO, 8'h00);
    rd_reg(`FRT_OFF_CNT_HI, v);
    run(16);
    rd_reg(`FRT_OFF_ALT_HI, v);
    rd_reg(`FRT_OFF_CNT_LO, v);
    chk(v, 16'h00fc);
    rd_reg(`FRT_OFF_ALT_LO, v);
    near({8'h00, v}, 16'h00fe);
    for (int e = 0; e < 2; e++) begin
      wr_reg(`FRT_OFF_CTRL_TWO, e ? 8'h0c : 8'h0e);
      wr_reg(`FRT_OFF_CNT_LO, 8'h00);
      @(posedge clk);
      halt <= 1'b0;
      u_frt_ext_src.toggle(5);
      repeat (8) @(posedge clk);
      halt <= 1'b1;
      rd16(`FRT_OFF_CNT_HI, w);
      chk(w, 16'hffff);
    end
    end_sim();
  end

  initial begin
    repeat (10000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule
